//--- src/kspi_consts.svh
// Constants of the knock processor serial configuration port.
// Included by the configuration module only; definitions only.
`ifndef KSPI_CONSTS_SVH
`define KSPI_CONSTS_SVH

// Frame
`define KSPI_WORD_BITS     8
`define KSPI_CNT_SAT       4'h_F

// Address prefixes and field positions
`define KSPI_PFX_FREQ      2'b00
`define KSPI_PFX_GAIN      2'b10
`define KSPI_PFX_PRESC     2'b01
`define KSPI_PFX_TC        3'b110
`define KSPI_PFX_TEST      3'b111
`define KSPI_Z_BIT         0
`define KSPI_CHAN_BIT      0

// Reset values
`define KSPI_RST_FREQ      6'h_00
`define KSPI_RST_GAIN      6'h_00
`define KSPI_RST_TC        5'h_00
`define KSPI_RST_PRESC     5'h_00
`define KSPI_RST_TEST      5'h_00
`define KSPI_RST_SO_HIZ    1'b1
`define KSPI_RST_PINS      5'h_02

// Diagnostic source codes in the test field
`define KSPI_DIAG_SI       4'h_5
`define KSPI_DIAG_CMP      4'h_6
`define KSPI_DIAG_REGS     4'h_5

`endif

//--- src/kspi_pkg.sv
// Types of the knock processor serial configuration port.
// Needs no other file.
package kspi_pkg;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_FRAME,
		ST_SPOIL
	} kspi_state_type;
endpackage

//--- src/kspi_sync.sv
// Three-stage input synchroniser with agreement filter.
// Inputs are asynchronous pins; output is a level on clk_i.
`timescale 1ns/1ns
`default_nettype none
module kspi_sync #(
	parameter int          WIDTH   = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             sys_rst_i,
	// Pins and filtered levels
	input  wire logic [WIDTH-1:0] pin_i,
	output logic      [WIDTH-1:0] level_o
);
	logic [WIDTH-1:0] s1_ff, s2_ff, s3_ff, lvl_ff;
	logic [WIDTH-1:0] nxt_lvl;

	// First stage feeds the second stage only
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		assign nxt_lvl[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : lvl_ff[i];
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s1_ff  <= RST_VAL;
			s2_ff  <= RST_VAL;
			s3_ff  <= RST_VAL;
			lvl_ff <= RST_VAL;
		end else begin
			s1_ff  <= pin_i;
			s2_ff  <= s1_ff;
			s3_ff  <= s2_ff;
			lvl_ff <= nxt_lvl;
		end
	end

	assign level_o = lvl_ff;
endmodule
`default_nettype wire

//--- src/kspi_config.sv
// Serial configuration port of the knock processor: frame filter,
// word decode, five control registers, lookups and diagnostic output.
// Assumes serial pins arrive asynchronously and clk_i outruns the serial clock.
// Notes on behaviour
// - Eight bits shifted in while selected
// - Address picks one of five registers
// - Registers: frequency, gain, time, prescale, test
// - Test register holds test modes and channel
// - Select rising loads word into register
// - Only exactly eight-bit frames change registers
// - Words accepted during integration mode too
// - Prescale bits pick 4 to 24 MHz
// - Codes map to frequency, gain, time constant
// - Diagnostic mux drives register, input, comparator
// - Prefixes 00,10,01,110,111 select registers
// - Words travel most significant bit first
// - Data captured on serial clock falling edge
// - Last prescale bit sets output high impedance
`include "kspi_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module kspi_config (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	// Serial pins
	input  wire logic        sck_pin_i,
	input  wire logic        cs_n_pin_i,
	input  wire logic        si_pin_i,
	output logic             so_o,
	output logic             so_oe_o,
	// Diagnostic pins
	input  wire logic        test_en_i,
	input  wire logic        comp_i,
	// Control register contents
	output logic [5:0]       freq_code_o,
	output logic [5:0]       gain_code_o,
	output logic [4:0]       tc_code_o,
	output logic [3:0]       prescale_o,
	output logic [3:0]       test_sel_o,
	output logic             channel_choice_bit_o,
	// Looked-up settings
	output logic [10:0]      freq_10hz_o,
	output logic [10:0]      gain_milli_o,
	output logic [9:0]       tc_us_o,
	output logic [4:0]       ref_clk_mhz_o,
	// Frame outcome pulses
	output logic             word_ok_o,
	output logic             word_drop_o
);
	localparam logic [10:0] FREQ_TAB [64] = '{
		11'd122, 11'd126, 11'd131, 11'd135, 11'd140, 11'd145, 11'd151, 11'd157,
		11'd163, 11'd171, 11'd178, 11'd187, 11'd196, 11'd207, 11'd218, 11'd231,
		11'd246, 11'd254, 11'd262, 11'd271, 11'd281, 11'd292, 11'd303, 11'd315,
		11'd328, 11'd343, 11'd359, 11'd376, 11'd395, 11'd416, 11'd439, 11'd466,
		11'd495, 11'd512, 11'd529, 11'd548, 11'd568, 11'd590, 11'd612, 11'd637,
		11'd664, 11'd694, 11'd727, 11'd763, 11'd802, 11'd846, 11'd895, 11'd950,
		11'd1012, 11'd1046, 11'd1083, 11'd1122, 11'd1165, 11'd1210, 11'd1260,
		11'd1314, 11'd1372, 11'd1436, 11'd1507, 11'd1584, 11'd1671, 11'd1767,
		11'd1876, 11'd1998};
	localparam logic [10:0] GAIN_TAB [64] = '{
		11'd2000, 11'd1882, 11'd1778, 11'd1684, 11'd1600, 11'd1523, 11'd1455,
		11'd1391, 11'd1333, 11'd1280, 11'd1231, 11'd1185, 11'd1143, 11'd1063,
		11'd1000, 11'd944, 11'd895, 11'd850, 11'd810, 11'd773, 11'd739, 11'd708,
		11'd680, 11'd654, 11'd630, 11'd607, 11'd586, 11'd567, 11'd548, 11'd500,
		11'd471, 11'd444, 11'd421, 11'd400, 11'd381, 11'd364, 11'd348, 11'd333,
		11'd320, 11'd308, 11'd296, 11'd286, 11'd276, 11'd267, 11'd258, 11'd250,
		11'd236, 11'd222, 11'd211, 11'd200, 11'd190, 11'd182, 11'd174, 11'd167,
		11'd160, 11'd154, 11'd148, 11'd143, 11'd138, 11'd133, 11'd129, 11'd125,
		11'd118, 11'd111};
	localparam logic [9:0] TC_TAB [32] = '{
		10'd40, 10'd45, 10'd50, 10'd55, 10'd60, 10'd65, 10'd70, 10'd75,
		10'd80, 10'd90, 10'd100, 10'd110, 10'd120, 10'd130, 10'd140, 10'd150,
		10'd160, 10'd180, 10'd200, 10'd220, 10'd240, 10'd260, 10'd280, 10'd300,
		10'd320, 10'd360, 10'd400, 10'd440, 10'd480, 10'd520, 10'd560, 10'd600};

	logic [4:0] pins_f;
	logic       sck_f, cs_n_f, si_f, test_f, comp_f;

	kspi_sync #(
		.WIDTH   (5),
		.RST_VAL (`KSPI_RST_PINS)
	) u_sync (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.pin_i     ({comp_i, test_en_i, si_pin_i, cs_n_pin_i, sck_pin_i}),
		.level_o   (pins_f)
	);
	assign {comp_f, test_f, si_f, cs_n_f, sck_f} = pins_f;

	// Frame state
	kspi_pkg::kspi_state_type state_ff, nxt_state;
	logic       sck_d_ff, cs_n_d_ff;
	logic [3:0] cnt_ff, nxt_cnt;
	logic [7:0] shreg_ff, nxt_shreg;
	logic [7:0] img_ff, nxt_img;
	logic       load, drop, sck_fall, cs_fall, cs_rise;

	// Control registers and outputs
	logic [5:0] freq_ff, nxt_freq, gain_ff, nxt_gain;
	logic [4:0] tc_ff, nxt_tc, presc_ff, nxt_presc, test_ff, nxt_test;
	logic       hiz_ff, nxt_hiz, so_ff, nxt_so, ok_ff, drop_ff, oe_ff, nxt_oe;
	logic [10:0] f10_ff, nxt_f10, gm_ff, nxt_gm;
	logic [9:0] tcus_ff, nxt_tcus;
	logic [4:0] mhz_ff, nxt_mhz;

	assign sck_fall = sck_d_ff & ~sck_f;
	assign cs_fall  = cs_n_d_ff & ~cs_n_f;
	assign cs_rise  = ~cs_n_d_ff & cs_n_f;

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		nxt_shreg = shreg_ff;
		nxt_img   = img_ff;
		load      = 1'b0;
		drop      = 1'b0;
		case (state_ff)
			kspi_pkg::ST_IDLE: begin
				if (cs_fall) begin
					// A high clock at select fall spoils the frame
					nxt_state = sck_f ? kspi_pkg::ST_SPOIL : kspi_pkg::ST_FRAME;
					nxt_cnt   = 4'h_0;
					case (test_ff[4:1])
						4'h_0:   nxt_img = {`KSPI_PFX_FREQ, freq_ff};
						4'h_1:   nxt_img = {`KSPI_PFX_GAIN, gain_ff};
						4'h_2:   nxt_img = {`KSPI_PFX_TC, tc_ff};
						4'h_3:   nxt_img = {`KSPI_PFX_PRESC, presc_ff, hiz_ff};
						default: nxt_img = {`KSPI_PFX_TEST, test_ff};
					endcase
				end
			end
			kspi_pkg::ST_FRAME: begin
				if (cs_rise) begin
					nxt_state = kspi_pkg::ST_IDLE;
					// Load happens whatever the integrate/hold level is
					load = (cnt_ff == 4'(`KSPI_WORD_BITS)) && !sck_f;
					drop = !load;
				end else if (sck_fall) begin
					nxt_shreg = {shreg_ff[6:0], si_f};
					nxt_img   = {img_ff[6:0], 1'b0};
					if (cnt_ff != `KSPI_CNT_SAT) begin
						nxt_cnt = 4'(cnt_ff + 4'h_1);
					end
				end
			end
			kspi_pkg::ST_SPOIL: begin
				if (cs_rise) begin
					nxt_state = kspi_pkg::ST_IDLE;
					drop      = 1'b1;
				end
			end
			default: nxt_state = kspi_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_ff  <= kspi_pkg::ST_IDLE;
			cnt_ff    <= 4'h_0;
			shreg_ff  <= 8'h_00;
			img_ff    <= 8'h_00;
			sck_d_ff  <= 1'b0;
			cs_n_d_ff <= 1'b1;
		end else begin
			state_ff  <= nxt_state;
			cnt_ff    <= nxt_cnt;
			shreg_ff  <= nxt_shreg;
			img_ff    <= nxt_img;
			sck_d_ff  <= sck_f;
			cs_n_d_ff <= cs_n_f;
		end
	end

	// Decode, lookups and diagnostic output
	always_comb begin
		nxt_freq  = freq_ff;
		nxt_gain  = gain_ff;
		nxt_tc    = tc_ff;
		nxt_presc = presc_ff;
		nxt_hiz   = hiz_ff;
		nxt_test  = test_ff;
		if (load) begin
			if (shreg_ff[7:6] == `KSPI_PFX_FREQ) begin
				nxt_freq = shreg_ff[5:0];
			end else if (shreg_ff[7:6] == `KSPI_PFX_GAIN) begin
				nxt_gain = shreg_ff[5:0];
			end else if (shreg_ff[7:6] == `KSPI_PFX_PRESC) begin
				nxt_presc = shreg_ff[5:1];
				nxt_hiz   = shreg_ff[`KSPI_Z_BIT];
			end else if (shreg_ff[7:5] == `KSPI_PFX_TC) begin
				nxt_tc = shreg_ff[4:0];
			end else begin
				nxt_test = shreg_ff[4:0];
			end
		end
		nxt_f10  = FREQ_TAB[nxt_freq];
		nxt_gm   = GAIN_TAB[nxt_gain];
		nxt_tcus = TC_TAB[nxt_tc];
		// Codes above 1000 have no defined rate; lowest rate is the safe reading
		case (nxt_presc[3:0])
			4'h_1:   nxt_mhz = 5'd5;
			4'h_2:   nxt_mhz = 5'd6;
			4'h_3:   nxt_mhz = 5'd8;
			4'h_4:   nxt_mhz = 5'd10;
			4'h_5:   nxt_mhz = 5'd12;
			4'h_6:   nxt_mhz = 5'd16;
			4'h_7:   nxt_mhz = 5'd20;
			4'h_8:   nxt_mhz = 5'd24;
			default: nxt_mhz = 5'd4;
		endcase
		nxt_oe = ~nxt_hiz;
		nxt_so = 1'b0;
		if (test_f) begin
			if (test_ff[4:1] < `KSPI_DIAG_REGS) begin
				nxt_so = img_ff[7];
			end else if (test_ff[4:1] == `KSPI_DIAG_SI) begin
				nxt_so = si_f;
			end else if (test_ff[4:1] == `KSPI_DIAG_CMP) begin
				nxt_so = comp_f;
			end
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			freq_ff  <= `KSPI_RST_FREQ;
			gain_ff  <= `KSPI_RST_GAIN;
			tc_ff    <= `KSPI_RST_TC;
			presc_ff <= `KSPI_RST_PRESC;
			hiz_ff   <= `KSPI_RST_SO_HIZ;
			test_ff  <= `KSPI_RST_TEST;
			f10_ff   <= FREQ_TAB[0];
			gm_ff    <= GAIN_TAB[0];
			tcus_ff  <= TC_TAB[0];
			mhz_ff   <= 5'd4;
			so_ff    <= 1'b0;
			oe_ff    <= ~`KSPI_RST_SO_HIZ;
			ok_ff    <= 1'b0;
			drop_ff  <= 1'b0;
		end else begin
			freq_ff  <= nxt_freq;
			gain_ff  <= nxt_gain;
			tc_ff    <= nxt_tc;
			presc_ff <= nxt_presc;
			hiz_ff   <= nxt_hiz;
			test_ff  <= nxt_test;
			f10_ff   <= nxt_f10;
			gm_ff    <= nxt_gm;
			tcus_ff  <= nxt_tcus;
			mhz_ff   <= nxt_mhz;
			so_ff    <= nxt_so;
			oe_ff    <= nxt_oe;
			ok_ff    <= load;
			drop_ff  <= drop;
		end
	end

	assign freq_code_o          = freq_ff;
	assign gain_code_o          = gain_ff;
	assign tc_code_o            = tc_ff;
	assign prescale_o           = presc_ff[3:0];
	assign test_sel_o           = test_ff[4:1];
	assign channel_choice_bit_o = test_ff[`KSPI_CHAN_BIT];
	assign freq_10hz_o          = f10_ff;
	assign gain_milli_o         = gm_ff;
	assign tc_us_o              = tcus_ff;
	assign ref_clk_mhz_o        = mhz_ff;
	assign so_o                 = so_ff;
	assign so_oe_o              = oe_ff;
	assign word_ok_o            = ok_ff;
	assign word_drop_o          = drop_ff;

	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_good_end;
		state_ff == kspi_pkg::ST_FRAME && cs_rise && cnt_ff == 4'h_8 && !sck_f;
	endsequence
	sequence s_bad_end;
		(state_ff == kspi_pkg::ST_FRAME && cs_rise && cnt_ff != 4'h_8)
			|| (state_ff == kspi_pkg::ST_SPOIL && cs_rise);
	endsequence

	a_shift_msb_first: assert property (
		state_ff == kspi_pkg::ST_FRAME && !cs_rise && sck_fall
			|=> shreg_ff[0] == $past(si_f) && shreg_ff[7:1] == $past(shreg_ff[6:0]))
		else $error("serial bit not shifted in at clock fall");
	a_good_frame_ok: assert property (s_good_end |=> word_ok_o && !word_drop_o)
		else $error("valid frame not accepted");
	a_bad_frame_kept: assert property (
		s_bad_end |=> word_drop_o && $stable(freq_code_o) && $stable(gain_code_o)
			&& $stable(tc_code_o) && $stable(prescale_o) && $stable(so_oe_o))
		else $error("bad frame changed a register");
	a_gain_decode: assert property (
		s_good_end ##0 shreg_ff[7:6] == 2'b10
			|=> gain_code_o == $past(shreg_ff[5:0]) && $stable(freq_code_o))
		else $error("gain word misrouted");
	a_tc_decode: assert property (
		s_good_end ##0 shreg_ff[7:5] == 3'b110
			|=> tc_code_o == $past(shreg_ff[4:0]) && $stable(test_sel_o))
		else $error("time constant word misrouted");
	a_chan_decode: assert property (
		s_good_end ##0 shreg_ff[7:5] == 3'b111
			|=> channel_choice_bit_o == $past(shreg_ff[0]) && $stable(tc_code_o))
		else $error("channel bit not loaded");
	a_presc_24mhz: assert property (
		s_good_end ##0 shreg_ff[7:6] == 2'b01 && shreg_ff[4:1] == 4'h_8
			|=> ref_clk_mhz_o == 5'd24)
		else $error("prescale code 1000 not 24 MHz");
	a_so_hiz_bit: assert property (
		s_good_end ##0 shreg_ff[7:6] == 2'b01 |=> so_oe_o == !$past(shreg_ff[0]))
		else $error("output enable does not follow last prescale bit");
	a_freq_lookup: assert property (
		s_good_end ##0 shreg_ff == 8'h_1A |=> freq_10hz_o == 11'd359)
		else $error("code 26 frequency wrong");
	a_spoil_frame: assert property (
		state_ff == kspi_pkg::ST_IDLE && cs_fall && sck_f |=> state_ff == kspi_pkg::ST_SPOIL)
		else $error("frame with high clock not spoiled");
	a_diag_si_echo: assert property (
		test_f && test_ff[4:1] == 4'h_5 |=> so_o == $past(si_f))
		else $error("diagnostic input echo wrong");
endmodule
`default_nettype wire

//--- sim/kspi_host.sv
// Host model: serial bus master that sends one word per request.
// Assumes requests arrive only while busy_o is low; levels last whole clk_i cycles.
`timescale 1ns/1ns
`default_nettype none
module kspi_host (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       sys_rst_i,
	// Request
	input  wire logic       go_i,
	input  wire logic [7:0] word_i,
	input  wire logic [3:0] pulses_i,
	input  wire logic [7:0] half_i,
	input  wire logic       spoil_i,
	output logic            busy_o,
	// Serial pins
	output logic            sck_o,
	output logic            cs_n_o,
	output logic            si_o
);
	task automatic wait_clk(input logic [7:0] n);
		repeat (n) @(posedge clk_i);
	endtask

	initial begin
		busy_o = 1'b0;
		sck_o  = 1'b0;
		cs_n_o = 1'b1;
		si_o   = 1'b0;
		forever begin
			@(posedge clk_i);
			if (go_i && !sys_rst_i) begin
				busy_o <= 1'b1;
				// A spoiled frame opens with the clock already high
				if (spoil_i) begin
					sck_o <= 1'b1;
					wait_clk(half_i);
				end
				cs_n_o <= 1'b0;
				for (int i = 0; i < pulses_i; i++) begin
					wait_clk(half_i);
					// Data moves with the rising clock so it is settled at the fall
					si_o  <= word_i[3'(7 - i)];
					sck_o <= 1'b1;
					wait_clk(half_i);
					sck_o <= 1'b0;
				end
				wait_clk(half_i);
				cs_n_o <= 1'b1;
				// Released data shows the inverse, so a stale bit never passes as driven
				si_o   <= ~si_o;
				busy_o <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

//--- sim/knock_processor_spi_config_test.sv
// Self-checking bench of the serial configuration port.
// Assumes the host model of kspi_host.sv; one clock, no random stimulus.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) check(32'(g), 32'(e))
module knock_processor_spi_config_test;
	logic        clk_i     = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic        go        = 1'b0;
	logic [7:0]  word      = 8'h_00;
	logic [3:0]  npulse    = 4'h_8;
	logic [7:0]  half      = 8'h_04;
	logic        test_en   = 1'b0;
	logic        comp      = 1'b0;
	logic        spoil     = 1'b0;
	logic        busy;
	logic        sck;
	logic        cs_n;
	logic        si;
	logic        so_o;
	logic        so_oe_o;
	logic [5:0]  freq_code_o;
	logic [5:0]  gain_code_o;
	logic [4:0]  tc_code_o;
	logic [3:0]  prescale_o;
	logic [3:0]  test_sel_o;
	logic        channel_choice_bit_o;
	logic [10:0] freq_10hz_o;
	logic [10:0] gain_milli_o;
	logic [9:0]  tc_us_o;
	logic [4:0]  ref_clk_mhz_o;
	logic        word_ok_o;
	logic        word_drop_o;
	int          bad_count  = 0;
	int          n_compared = 0;
	int          ok_cnt     = 0;
	int          drop_cnt   = 0;
	logic [4:0]  mhz [9] = '{5'h_04, 5'h_05, 5'h_06, 5'h_08, 5'h_0A, 5'h_0C, 5'h_10, 5'h_14, 5'h_18};

	kspi_host host (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .go_i(go), .word_i(word),
		.pulses_i(npulse), .half_i(half), .spoil_i(spoil), .busy_o(busy), .sck_o(sck),
		.cs_n_o(cs_n), .si_o(si));

	kspi_config dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sck_pin_i(sck), .cs_n_pin_i(cs_n),
		.si_pin_i(si), .so_o(so_o), .so_oe_o(so_oe_o), .test_en_i(test_en), .comp_i(comp),
		.freq_code_o(freq_code_o), .gain_code_o(gain_code_o), .tc_code_o(tc_code_o),
		.prescale_o(prescale_o), .test_sel_o(test_sel_o),
		.channel_choice_bit_o(channel_choice_bit_o), .freq_10hz_o(freq_10hz_o),
		.gain_milli_o(gain_milli_o), .tc_us_o(tc_us_o), .ref_clk_mhz_o(ref_clk_mhz_o),
		.word_ok_o(word_ok_o), .word_drop_o(word_drop_o));

	initial begin
		forever #4 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		if (word_ok_o === 1'b1) ok_cnt++;
		if (word_drop_o === 1'b1) drop_cnt++;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic final_report();
		$display("Compared %0d values, %0d mismatches", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// One frame of n pulses at h clocks per level, clock high at select fall when sp is set;
	// expects exactly one outcome pulse
	task automatic send(input logic [7:0] w, input int n = 8, input int h = 4,
		input logic sp = 1'b0);
		int k;
		int ok0;
		int dr0;
		k = 0;
		ok0 = ok_cnt;
		dr0 = drop_cnt;
		word   <= w;
		npulse <= 4'(n);
		half   <= 8'(h);
		spoil  <= sp;
		go     <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
		@(posedge clk_i);
		while (busy === 1'b1 && k < 3000) begin
			@(posedge clk_i);
			k++;
		end
		repeat (8) @(posedge clk_i);
		`CHK(k < 3000, 1'b1);
		`CHK(ok_cnt - ok0, n == 8 && !sp);
		`CHK(drop_cnt - dr0, n != 8 || sp);
	endtask

	initial begin
		repeat (12) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		@(posedge clk_i);
		`CHK({freq_10hz_o, gain_milli_o, tc_us_o}, {11'h_07A, 11'h_7D0, 10'h_028});
		`CHK({so_oe_o, ref_clk_mhz_o}, {1'b0, 5'h_04});
		send(8'h_1A);
		`CHK({freq_code_o, freq_10hz_o}, {6'h_1A, 11'h_167});
		send(8'h_3F, 8, 20);
		`CHK({freq_code_o, freq_10hz_o}, {6'h_3F, 11'h_7CE});
		send(8'h_9F);
		`CHK({gain_code_o, gain_milli_o}, {6'h_1F, 11'h_1BC});
		send(8'h_BA);
		`CHK({gain_code_o, gain_milli_o}, {6'h_3A, 11'h_08A});
		`CHK(freq_code_o, 6'h_3F);
		send(8'h_DA);
		`CHK({tc_code_o, tc_us_o}, {5'h_1A, 10'h_190});
		send(8'h_DF);
		`CHK({tc_code_o, tc_us_o, gain_code_o}, {5'h_1F, 10'h_258, 6'h_3A});
		for (int i = 0; i < 9; i++) begin
			send({3'b011, 4'(i), 1'b0});
			`CHK({prescale_o, ref_clk_mhz_o, so_oe_o}, {4'(i), mhz[i], 1'b1});
		end
		send(8'h_41);
		`CHK({prescale_o, so_oe_o}, {4'h_0, 1'b0});
		send(8'h_E1);
		`CHK({test_sel_o, channel_choice_bit_o}, {4'h_0, 1'b1});
		// Short, long and spoiled frames must leave every register alone
		send(8'h_00, 7);
		send(8'h_00, 9);
		send(8'h_00, 8, 4, 1'b1);
		`CHK({freq_code_o, channel_choice_bit_o}, {6'h_3F, 1'b1});
		send(8'h_EC);
		`CHK({test_sel_o, channel_choice_bit_o}, {4'h_6, 1'b0});
		test_en <= 1'b1;
		comp    <= 1'b1;
		repeat (8) @(posedge clk_i);
		`CHK(so_o, 1'b1);
		comp <= 1'b0;
		repeat (8) @(posedge clk_i);
		`CHK(so_o, 1'b0);
		// Select 5 echoes the data pin, which rests at the inverse of the last bit
		send(8'h_EA);
		`CHK({test_sel_o, so_o}, {4'h_5, si});
		// Select 3 shows the prescale image; one clock fall exposes its second prefix bit
		send(8'h_E6);
		send(8'h_00, 1);
		`CHK({test_sel_o, so_o}, {4'h_3, 1'b1});
		test_en <= 1'b0;
		send(8'h_1A);
		`CHK(freq_10hz_o, 11'h_167);
		final_report();
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		bad_count++;
		final_report();
	end
endmodule
`default_nettype wire
